// *** ssp_board_model.sv ***
// board model: pull resistors and series indicator leds on the two shared pins
`timescale 1ns/1ps

module ssp_board_model
(
	input wire logic [1:0] i_pull,
	input wire logic [1:0] i_pin_out,
	input wire logic [1:0] i_pin_oe,
	output logic [1:0] o_pad,
	output logic [1:0] o_led_lit
);
	// ==========================================================
	// pad level
	// a released pad settles to its firm pull, so it never floats
	always_comb
	begin
		for (int i = 0; i < 2; i++)
			o_pad[i] = i_pin_oe[i] ? i_pin_out[i] : i_pull[i];
	end

	// the led sits in series with the pull, so it lights only when driven away from it
	assign o_led_lit = i_pin_oe & (i_pin_out ^ i_pull);
endmodule // ssp_board_model

// *** ssp_pin_cell.sv ***
// one shared strap / status pin: synchroniser, strap latch and indicator driver
`timescale 1ns/1ps

module ssp_pin_cell
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_pin_in,
	input wire logic i_sample,
	input wire logic i_event,
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_strap
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic strap;
		logic oe;
		logic out;
	} ssp_cell_type;

	ssp_cell_type state_reg;
	ssp_cell_type state_next;

	// ==========================================================
	// next state
	always_comb
	begin
		state_next = state_reg;
		state_next.sync1 = i_pin_in;
		state_next.sync2 = state_reg.sync1;
		// latch the pad once, then turn the pin round for good
		if (i_sample)
		begin
			state_next.strap = state_reg.sync2;
			state_next.oe = 1'b1;
		end
		// lit level is the inverse of the strap, dark level equals it
		state_next.out = state_next.oe ? (i_event ^ state_next.strap) : 1'b0;
	end

	// only the async reset clears the latch; soft reset never reaches here
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign o_pin_out = state_reg.out;
	assign o_pin_oe = state_reg.oe;
	assign o_strap = state_reg.strap;

endmodule // ssp_pin_cell

// *** ssp_pkg.sv ***
// shared constants for the strap and status pin block
package ssp_pkg;

	// ==========================================================
	// management register indices
	localparam logic [4:0] REG_CONTROL = 5'h00;
	localparam logic [4:0] REG_CONDITION = 5'h01;
	localparam logic [4:0] REG_ID_HIGH = 5'h02;
	localparam logic [4:0] REG_ID_LOW = 5'h03;
	localparam logic [4:0] REG_ADVERTISE = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] REG_EXPANSION = 5'h06;
	localparam logic [4:0] REG_NP_TX = 5'h07;
	localparam logic [4:0] REG_NP_PARTNER = 5'h08;
	localparam logic [4:0] REG_RESV_FIRST = 5'h09;
	localparam logic [4:0] REG_RESV_LAST = 5'h0f;
	localparam logic [4:0] REG_LED_CFG = 5'h14;

	// ==========================================================
	// control register fields
	localparam int CTL_SOFT_RESET = 15;
	localparam int CTL_ISOLATE = 10;
	localparam int CTL_AN_RESTART = 9;
	localparam logic [15:0] CTL_RESET = 16'h3100;
	localparam logic [15:0] CTL_WR_MASK = 16'h7d80;

	// condition register: fixed ability bits, link bit position
	localparam logic [15:0] COND_FIXED = 16'h7809;
	localparam int COND_LINK = 2;

	// other reset values
	localparam logic [15:0] ADV_RESET = 16'h01e1;
	localparam logic [15:0] NP_RESET = 16'h2001;
	localparam logic [15:0] LED_CFG_RESET = 16'h0010;

	// led configuration fields: pin a in [3:0], pin b in [7:4]
	localparam int LED_SEL_W = 4;
	localparam logic [3:0] SEL_LINK = 4'h0;
	localparam logic [3:0] SEL_ACTIVITY = 4'h1;
	localparam logic [3:0] SEL_TX = 4'h2;
	localparam logic [3:0] SEL_RX = 4'h3;
	localparam logic [3:0] SEL_COLLISION = 4'h4;
	localparam logic [3:0] SEL_SPEED = 4'h5;
	localparam logic [3:0] SEL_DUPLEX = 4'h6;

	// ==========================================================
	// timing: synchroniser depth before straps are sampled
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;

	// ==========================================================
	// start-up phases
	typedef enum logic [1:0] {
		PH_SETTLE = 2'b00,
		PH_SAMPLE = 2'b01,
		PH_RUN = 2'b10
	} ssp_phase_type;

endpackage

// *** ssp_strap_led.sv ***
// strap sampling, status indicator pins and management register space
`timescale 1ns/1ps

// Function
// - During power-on or hardware reset each shared pin is an input whose level is latched on leaving reset.
// - After the straps are latched each shared pin becomes an output driving an indicator.
// - A software reset leaves the latched straps and the pin state alone.
// - During a software reset every shared pin stays an output.
// - An active event drives the pin to the inverse of its latched level.
// - The board pulls each pin firmly; the latched levels form the management address.
// - A latched management address of zero puts the MAC-side outputs in high impedance.
// - The event shown on each pin is chosen by register 20 of the first register bank.
// - Each pin can show link, activity, transmit, receive, collision, speed or duplex.
// - The space holds 32 registers: control, condition, identifier, negotiation, reserved, vendor.
module ssp_strap_led
#(
	parameter logic [15:0] ID_HIGH = 16'h1234, // arbitrary value
	parameter logic [15:0] ID_LOW = 16'h5670 // arbitrary value
)
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [1:0] i_pin_in,
	output logic [1:0] o_pin_out,
	output logic [1:0] o_pin_oe,
	output logic [1:0] o_mgmt_addr,
	output logic o_mac_hiz,
	output logic o_soft_reset,
	input wire logic i_link_up,
	input wire logic i_activity,
	input wire logic i_tx_active,
	input wire logic i_rx_active,
	input wire logic i_collision,
	input wire logic i_speed_100,
	input wire logic i_full_duplex,
	input wire logic [4:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata
);

	typedef struct packed {
		ssp_pkg::ssp_phase_type phase;
		logic [1:0] settle;
		logic sw_rst;
		logic [15:0] ctrl;
		logic [15:0] adv;
		logic [15:0] np;
		logic [15:0] led_cfg;
		logic [15:0] rdata;
	} ssp_state_type;

	ssp_state_type state_reg;
	ssp_state_type state_next;
	logic [1:0] ev_vec;
	logic [1:0] strap;
	logic sample;

	// ==========================================================
	// event selection, shared by both pins
	function automatic logic ssp_pick(input logic [3:0] sel, input logic [6:0] evs);
		logic r;
		r = 1'b0;
		unique case (sel)
			ssp_pkg::SEL_LINK: r = evs[0];
			ssp_pkg::SEL_ACTIVITY: r = evs[1];
			ssp_pkg::SEL_TX: r = evs[2];
			ssp_pkg::SEL_RX: r = evs[3];
			ssp_pkg::SEL_COLLISION: r = evs[4];
			ssp_pkg::SEL_SPEED: r = evs[5];
			ssp_pkg::SEL_DUPLEX: r = evs[6];
			default: r = 1'b0; // unused codes keep the indicator dark
		endcase
		return r;
	endfunction

	// ==========================================================
	// pin cells
	assign sample = (state_reg.phase == ssp_pkg::PH_SAMPLE);

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_pin
			// each pin chooses its own event from its config field
			assign ev_vec[g] = ssp_pick(state_reg.led_cfg[g*ssp_pkg::LED_SEL_W +: ssp_pkg::LED_SEL_W],
				{i_full_duplex, i_speed_100, i_collision, i_rx_active, i_tx_active,
				i_activity, i_link_up});
			ssp_pin_cell u_cell
			(
				.i_mclk(i_mclk),
				.i_arst_n(i_arst_n),
				.i_pin_in(i_pin_in[g]),
				.i_sample(sample),
				.i_event(ev_vec[g]),
				.o_pin_out(o_pin_out[g]),
				.o_pin_oe(o_pin_oe[g]),
				.o_strap(strap[g])
			);
		end
	endgenerate

	// ==========================================================
	// start-up sequence, soft reset and register access
	always_comb
	begin
		state_next = state_reg;
		state_next.sw_rst = 1'b0;
		state_next.ctrl[ssp_pkg::CTL_SOFT_RESET] = 1'b0;
		state_next.ctrl[ssp_pkg::CTL_AN_RESTART] = 1'b0;
		unique case (state_reg.phase)
			// wait for the synchronisers to fill so the sample is the pad level
			ssp_pkg::PH_SETTLE:
			begin
				state_next.settle = state_reg.settle + 2'h1;
				if (state_reg.settle == ssp_pkg::SETTLE_CYCLES - 2'h1)
					state_next.phase = ssp_pkg::PH_SAMPLE;
			end
			ssp_pkg::PH_SAMPLE:
				state_next.phase = ssp_pkg::PH_RUN;
			ssp_pkg::PH_RUN:
				state_next.phase = ssp_pkg::PH_RUN;
			default:
				state_next.phase = ssp_pkg::PH_SETTLE;
		endcase
		// registers return to defaults; straps and pin direction do not
		if (state_reg.sw_rst)
		begin
			state_next.ctrl = ssp_pkg::CTL_RESET;
			state_next.adv = ssp_pkg::ADV_RESET;
			state_next.np = ssp_pkg::NP_RESET;
			state_next.led_cfg = ssp_pkg::LED_CFG_RESET;
		end
		else if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				ssp_pkg::REG_CONTROL:
				begin
					state_next.ctrl = i_reg_wdata & ssp_pkg::CTL_WR_MASK;
					state_next.sw_rst = i_reg_wdata[ssp_pkg::CTL_SOFT_RESET];
				end
				ssp_pkg::REG_ADVERTISE: state_next.adv = i_reg_wdata;
				ssp_pkg::REG_NP_TX: state_next.np = i_reg_wdata;
				ssp_pkg::REG_LED_CFG: state_next.led_cfg = i_reg_wdata;
				default: ;
			endcase
		end
		// read map: 32 entries, reserved and unknown vendor ones read zero
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				ssp_pkg::REG_CONTROL: state_next.rdata = state_reg.ctrl;
				ssp_pkg::REG_CONDITION:
					state_next.rdata = ssp_pkg::COND_FIXED | ({15'h0000, i_link_up} << ssp_pkg::COND_LINK);
				ssp_pkg::REG_ID_HIGH: state_next.rdata = ID_HIGH;
				ssp_pkg::REG_ID_LOW: state_next.rdata = ID_LOW;
				ssp_pkg::REG_ADVERTISE: state_next.rdata = state_reg.adv;
				ssp_pkg::REG_NP_TX: state_next.rdata = state_reg.np;
				ssp_pkg::REG_LED_CFG: state_next.rdata = state_reg.led_cfg;
				default: state_next.rdata = 16'h0000; // partner regs have no source here
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state_reg <= '0;
			state_reg.phase <= ssp_pkg::PH_SETTLE;
			state_reg.ctrl <= ssp_pkg::CTL_RESET;
			state_reg.adv <= ssp_pkg::ADV_RESET;
			state_reg.np <= ssp_pkg::NP_RESET;
			state_reg.led_cfg <= ssp_pkg::LED_CFG_RESET;
		end
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// outputs
	assign o_mgmt_addr = strap;
	// straps unknown until latched, so the MAC side stays off till then
	assign o_mac_hiz = (state_reg.phase != ssp_pkg::PH_RUN) || (strap == 2'b00)
		|| state_reg.ctrl[ssp_pkg::CTL_ISOLATE];
	assign o_soft_reset = state_reg.sw_rst;
	assign o_reg_rdata = state_reg.rdata;

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	logic run;
	assign run = (state_reg.phase == ssp_pkg::PH_RUN);

	property p_input_in_reset;
		!run && !sample |-> o_pin_oe == 2'b00;
	endproperty
	a_input_in_reset: assert property (p_input_in_reset) else $error("pin driven before strap");

	sequence s_sampled;
		sample ##1 run;
	endsequence
	property p_output_after;
		s_sampled |-> o_pin_oe == 2'b11;
	endproperty
	a_output_after: assert property (p_output_after) else $error("pin not turned to output");

	property p_soft_keep;
		o_soft_reset |=> $stable(o_mgmt_addr) ##1 $stable(o_mgmt_addr);
	endproperty
	a_soft_keep: assert property (p_soft_keep) else $error("soft reset moved straps");

	property p_soft_oe;
		run && o_soft_reset |-> o_pin_oe == 2'b11 ##1 o_pin_oe == 2'b11;
	endproperty
	a_soft_oe: assert property (p_soft_oe) else $error("pin released in soft reset");

	property p_lit;
		run && ev_vec[0] |=> o_pin_out[0] != o_mgmt_addr[0];
	endproperty
	a_lit: assert property (p_lit) else $error("active level not inverse of strap");

	property p_dark;
		run && !ev_vec[1] |=> o_pin_out[1] == o_mgmt_addr[1];
	endproperty
	a_dark: assert property (p_dark) else $error("idle level differs from strap");

	property p_hiz;
		o_mgmt_addr == 2'b00 |-> o_mac_hiz;
	endproperty
	a_hiz: assert property (p_hiz) else $error("address zero not isolated");

	property p_cfg_write;
		i_reg_wr && i_reg_addr == ssp_pkg::REG_LED_CFG && !o_soft_reset
			|=> state_reg.led_cfg == $past(i_reg_wdata);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("led config not written");

	property p_col_select;
		run && state_reg.led_cfg[3:0] == ssp_pkg::SEL_COLLISION |-> ev_vec[0] == i_collision;
	endproperty
	a_col_select: assert property (p_col_select) else $error("collision not routed");

	property p_reserved_zero;
		i_reg_rd && i_reg_addr >= ssp_pkg::REG_RESV_FIRST && i_reg_addr <= ssp_pkg::REG_RESV_LAST
			|=> o_reg_rdata == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved reg not zero");

endmodule // ssp_strap_led

// *** testbench.sv ***
// self-checking bench for the strap sampling and status pin block
`timescale 1ns/1ps

module testbench;
	localparam logic [15:0] IDH = 16'h0a5c; // arbitrary value
	localparam logic [15:0] IDL = 16'h3c90; // arbitrary value
	logic i_mclk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [1:0] pull = 2'h2;
	logic [1:0] pad, pin_out, pin_oe, addr_q, lit;
	logic hiz, srst;
	logic [6:0] ev = 7'h00;
	logic [4:0] ra = 5'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] wd = 16'h0000;
	logic [15:0] rdat;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n_srst = 0;
	int since_rel = 0;
	logic [4:0] ta [7] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h07, 5'h14, 5'h09};
	logic [15:0] te [7] = '{ssp_pkg::CTL_RESET, IDH, IDL, ssp_pkg::ADV_RESET,
		ssp_pkg::NP_RESET, ssp_pkg::LED_CFG_RESET, 16'h0000};

	// ==========================================================
	// clock and instances
	always #2 i_mclk = ~i_mclk;

	ssp_board_model board (.i_pull(pull), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
		.o_pad(pad), .o_led_lit(lit));

	ssp_strap_led #(.ID_HIGH(IDH), .ID_LOW(IDL)) DUT (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_pin_in(pad), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_mgmt_addr(addr_q),
		.o_mac_hiz(hiz), .o_soft_reset(srst), .i_link_up(ev[0]), .i_activity(ev[1]),
		.i_tx_active(ev[2]), .i_rx_active(ev[3]), .i_collision(ev[4]),
		.i_speed_100(ev[5]), .i_full_duplex(ev[6]), .i_reg_addr(ra), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat));

	// ==========================================================
	// report and compare
	task automatic give_verdict();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check16(string nm, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic check2(string nm, logic [1:0] e, logic [1:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask

	// ==========================================================
	// register access: one-cycle strobes launched at the falling edge
	task automatic wreg(logic [4:0] a, logic [15:0] d);
		@(negedge i_mclk);
		ra = a;
		wd = d;
		wr = 1'b1;
		@(negedge i_mclk);
		wr = 1'b0;
	endtask

	task automatic rchk(logic [4:0] a, logic [15:0] e);
		@(negedge i_mclk);
		ra = a;
		rd = 1'b1;
		@(negedge i_mclk);
		rd = 1'b0;
		check16("rdata", e, rdat);
	endtask

	// pull flips mid-reset: only the level at release may be latched
	task automatic do_reset(logic [1:0] p);
		@(negedge i_mclk);
		i_arst_n = 1'b0;
		pull = ~p;
		repeat (10) @(negedge i_mclk);
		pull = p;
		repeat (10) @(negedge i_mclk);
		check2("oe in reset", 2'h0, pin_oe);
		check2("hiz in reset", 2'h1, {1'b0, hiz});
		i_arst_n = 1'b1;
		repeat (5) @(negedge i_mclk);
		check2("oe", 2'h3, pin_oe);
		check2("addr", p, addr_q);
		check2("hiz", {1'b0, p == 2'h0}, {1'b0, hiz});
	endtask

	// every event code on both pins, then all other events active at once
	task automatic led_sweep(logic [1:0] p);
		for (int c = 0; c < 7; c++)
		begin
			wreg(5'h14, {8'h00, c[3:0], c[3:0]});
			ev = 7'h01 << c;
			repeat (2) @(negedge i_mclk);
			check2("led on", ~p, pin_out);
			check2("lit", 2'h3, lit);
			ev = ~(7'h01 << c);
			repeat (2) @(negedge i_mclk);
			check2("led off", p, pin_out);
			check2("dark", 2'h0, lit);
		end
		ev = 7'h00;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		do_reset(2'h2);
		for (int i = 0; i < 7; i++)
			rchk(ta[i], te[i]);
		wreg(5'h01, 16'hffff);
		wreg(5'h1f, 16'hffff);
		rchk(5'h01, ssp_pkg::COND_FIXED);
		rchk(5'h1f, 16'h0000);
		ev = 7'h01;
		rchk(5'h01, ssp_pkg::COND_FIXED | 16'h0004);
		led_sweep(2'h2);
		wreg(5'h00, 16'h0400);
		check2("isolate", 2'h1, {1'b0, hiz});
		wreg(5'h14, 16'h0042);
		wreg(5'h00, 16'h8000);
		repeat (3) @(negedge i_mclk);
		check2("soft pulse", 2'h1, n_srst[1:0]);
		check2("oe soft", 2'h3, pin_oe);
		check2("addr soft", 2'h2, addr_q);
		rchk(5'h14, ssp_pkg::LED_CFG_RESET);
		rchk(5'h00, ssp_pkg::CTL_RESET);
		led_sweep(2'h2);
		do_reset(2'h0);
		do_reset(2'h1);
		led_sweep(2'h1);
		give_verdict();
	end

	// pulse counter, pin direction watch and hang guard
	// the watch waits a few cycles after every release, since the straps need three edges
	always @(negedge i_mclk)
	begin
		if (srst === 1'b1)
			n_srst++;
		if (!i_arst_n)
			since_rel = 0;
		else
			since_rel++;
		if (i_arst_n && since_rel > 4)
			check2("oe run", 2'h3, pin_oe);
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			$display("CHECK FAILED timeout exp %0d got %0d", 2999, cyc);
			give_verdict();
		end
	end
endmodule // testbench
